/* File: include/csc_pkg.sv */
// Package for the capacitive sense oscillator control block
package csc_pkg;
   // ****************************************
   // Register indices (word addresses)
   // ****************************************
   localparam logic [3:0] CSC_SENSE_CONTROL_0 = 4'h0;
   localparam logic [3:0] CSC_SENSE_CONTROL_1 = 4'h1;
   localparam logic [3:0] CSC_OPTION = 4'h2;
   localparam logic [3:0] CSC_TIMER16_CONTROL = 4'h3;
   localparam logic [3:0] CSC_TIMER8_COUNT = 4'h4;
   localparam logic [3:0] CSC_TIMER16_COUNT = 4'h5;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CSC_ENABLE_BIT = 7;
   localparam int CSC_REFMODE_BIT = 6;
   localparam int CSC_RANGE_LSB = 2;
   localparam int CSC_PHASE_BIT = 1;
   localparam int CSC_T8SENSE_BIT = 0;
   localparam int CSC_T8CS_BIT = 5;
   localparam int CSC_T16CS_LSB = 6;
   localparam int CSC_T16GE_BIT = 1;
   localparam int CSC_T16ON_BIT = 0;
   // ****************************************
   // Codes and reset values
   // ****************************************
   localparam logic [1:0] CSC_RANGE_OFF = 2'h0;
   localparam logic [1:0] CSC_T16CS_SENSE = 2'h3;
   localparam logic [7:0] CSC_CTRL_RST = 8'h00;
   localparam logic [7:0] CSC_OPTION_RST = 8'h00;
   localparam logic [3:0] CSC_NO_CHANNEL = 4'h0;
   typedef enum logic [2:0] {
      CSC_OSC_OFF = 3'b001,
      CSC_OSC_RUN = 3'b010,
      CSC_OSC_NOISE = 3'b100
   } csc_osc_state_t;
endpackage

/* File: hw/csc_top.sv */
// Capacitive sense oscillator control, clock routing and timers
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
// Operation
// - Software can read whether the oscillator is sourcing or sinking current.
// - The oscillator output can clock either the 8-bit or the 16-bit timer.
// - One reference-mode bit picks variable references when set, fixed when clear.
// - A 2-bit range field gives off, low, medium, high in fixed mode.
// - In variable mode code 00 is noise detection: no charge current, oscillator on.
// - The 8-bit timer counts the oscillator when its sense select is set and option clock select is clear.
// - The 16-bit timer counts the oscillator when its clock-source field is 11.
// - The 16-bit timer is off with on=0, free with gate enable 0, gated with both set.
// - A module enable bit turns the sensing module on or off.
// - While disabled the channel field is ignored and no channel is connected.
module csc_top
   import csc_pkg::*;
#(
   parameter int CH_W = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Analog front end
   input wire logic osc_comp_in,
   input wire logic timer8_ext_clk,
   input wire logic timer16_gate_in,
   input wire logic timer16_alt_clk,
   output logic sense_module_enable,
   output logic reference_mode_sel,
   output logic [1:0] current_range_sel,
   output logic charge_source_en,
   output logic osc_core_en,
   output logic [CH_W-1:0] sense_channel_sel,
   output logic channel_connect,
   output logic timer8_overflow
);
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] ctrl0_reg, ctrl0_next;
   logic [3:0] ctrl1_reg, ctrl1_next;
   logic [7:0] opt_reg, opt_next;
   logic [7:0] t16c_reg, t16c_next;
   logic [7:0] t8_reg, t8_next;
   logic [15:0] t16_reg, t16_next;
   logic [2:0] phs_reg, phs_next;
   logic [2:0] t8s_reg, t8s_next;
   logic [2:0] t16s_reg, t16s_next;
   logic [15:0] rd_reg, rd_next;
   logic ovf_reg, ovf_next;
   csc_osc_state_t st_reg, st_next;
   logic osc_rise, t8_tick, t16_tick, t8_src, t16_src, t16_run;

   function automatic logic rise(input logic [2:0] s);
      rise = s[1] & ~s[2];
   endfunction

   // Timer8 follows the oscillator only with its sense select set and the core tick off
   function automatic logic t8_on_sense(input logic [7:0] ctrl0, input logic [7:0] opt);
      t8_on_sense = ctrl0[CSC_T8SENSE_BIT] & ~opt[CSC_T8CS_BIT];
   endfunction

   function automatic logic t16_on_sense(input logic [7:0] t16c);
      t16_on_sense = t16c[CSC_T16CS_LSB +: 2] == CSC_T16CS_SENSE;
   endfunction

   // ****************************************
   // Oscillator mode and clock routing
   // ****************************************
   always_comb begin
      if (!ctrl0_reg[CSC_ENABLE_BIT]) begin
         st_next = CSC_OSC_OFF;
      end else if (ctrl0_reg[CSC_RANGE_LSB +: 2] == CSC_RANGE_OFF) begin
         // Noise mode keeps the core running with no charge current
         st_next = ctrl0_reg[CSC_REFMODE_BIT] ? CSC_OSC_NOISE : CSC_OSC_OFF;
      end else begin
         st_next = CSC_OSC_RUN;
      end
      // Sync chain: stage 0 is only read by stage 1
      phs_next = {phs_reg[1:0], osc_comp_in};
      osc_rise = rise(phs_reg) & (st_reg != CSC_OSC_OFF);
      t8_src = t8_on_sense(ctrl0_reg, opt_reg) ? phs_reg[1] : timer8_ext_clk;
      t16_src = t16_on_sense(t16c_reg) ? phs_reg[1] : timer16_alt_clk;
      t8s_next = {t8s_reg[1:0], t8_src};
      t16s_next = {t16s_reg[1:0], t16_src};
      // One count per rising edge of the synchronised source, or one per core clock with option clock select set
      // Limitation: each source level must last more than one core clock or edges are lost
      if (opt_reg[CSC_T8CS_BIT]) begin
         t8_tick = 1'b1;
      end else if (t8_on_sense(ctrl0_reg, opt_reg)) begin
         t8_tick = osc_rise;
      end else begin
         t8_tick = rise(t8s_reg);
      end
      if (t16_on_sense(t16c_reg)) begin
         t16_tick = osc_rise;
      end else begin
         t16_tick = rise(t16s_reg);
      end
      t16_run = t16c_reg[CSC_T16ON_BIT] & (~t16c_reg[CSC_T16GE_BIT] | timer16_gate_in);
   end

   // ****************************************
   // Register file and counters
   // ****************************************
   always_comb begin
      ctrl0_next = ctrl0_reg;
      ctrl1_next = ctrl1_reg;
      opt_next = opt_reg;
      t16c_next = t16c_reg;
      t8_next = t8_tick ? t8_reg + 8'h01 : t8_reg;
      ovf_next = t8_tick && (t8_reg == 8'hFF);
      t16_next = (t16_run && t16_tick) ? t16_reg + 16'h0001 : t16_reg;
      // Phase bit is hardware state, not writable
      ctrl0_next[CSC_PHASE_BIT] = (st_reg != CSC_OSC_OFF) & phs_reg[1];
      // Unmapped indices ignore writes and read as zero
      if (reg_wr) begin
         case (reg_addr)
            CSC_SENSE_CONTROL_0: begin
               // Bits 5:4 are not implemented and stay zero
               ctrl0_next = {reg_wdata[7:6], 2'b00, reg_wdata[3:2], ctrl0_next[CSC_PHASE_BIT], reg_wdata[0]};
            end
            CSC_SENSE_CONTROL_1: ctrl1_next = reg_wdata[3:0];
            CSC_OPTION: opt_next = reg_wdata[7:0];
            CSC_TIMER16_CONTROL: t16c_next = reg_wdata[7:0];
            // A count write wins over a tick in the same cycle, overflow included
            CSC_TIMER8_COUNT: begin
               t8_next = reg_wdata[7:0];
               ovf_next = 1'b0;
            end
            CSC_TIMER16_COUNT: t16_next = reg_wdata;
            default: ;
         endcase
      end
      // Read data stands only in the cycle after the strobe
      rd_next = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            CSC_SENSE_CONTROL_0: rd_next = {8'h00, ctrl0_reg};
            CSC_SENSE_CONTROL_1: rd_next = {12'h000, ctrl1_reg};
            CSC_OPTION: rd_next = {8'h00, opt_reg};
            CSC_TIMER16_CONTROL: rd_next = {8'h00, t16c_reg};
            CSC_TIMER8_COUNT: rd_next = {8'h00, t8_reg};
            CSC_TIMER16_COUNT: rd_next = t16_reg;
            default: rd_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl0_reg <= CSC_CTRL_RST;
         ctrl1_reg <= CSC_NO_CHANNEL;
         opt_reg <= CSC_OPTION_RST;
         t16c_reg <= CSC_CTRL_RST;
         t8_reg <= 8'h00;
         t16_reg <= 16'h0000;
         phs_reg <= 3'h0;
         t8s_reg <= 3'h0;
         t16s_reg <= 3'h0;
         rd_reg <= 16'h0000;
         ovf_reg <= 1'b0;
         st_reg <= CSC_OSC_OFF;
      end else begin
         ctrl0_reg <= ctrl0_next;
         ctrl1_reg <= ctrl1_next;
         opt_reg <= opt_next;
         t16c_reg <= t16c_next;
         t8_reg <= t8_next;
         t16_reg <= t16_next;
         phs_reg <= phs_next;
         t8s_reg <= t8s_next;
         t16s_reg <= t16s_next;
         rd_reg <= rd_next;
         ovf_reg <= ovf_next;
         st_reg <= st_next;
      end
   end

   // ****************************************
   // Front-end controls, all registered
   // ****************************************
   // One more flop stage so every pin is a register output
   logic [CH_W+5:0] fe_reg, fe_next;
   always_comb begin
      fe_next[0] = ctrl0_reg[CSC_ENABLE_BIT];
      fe_next[1] = ctrl0_reg[CSC_REFMODE_BIT];
      fe_next[3:2] = ctrl0_reg[CSC_RANGE_LSB +: 2];
      fe_next[4] = st_next == CSC_OSC_RUN;
      fe_next[5] = st_next != CSC_OSC_OFF;
      fe_next[CH_W+5:6] = ctrl0_reg[CSC_ENABLE_BIT] ? ctrl1_reg[CH_W-1:0] : CSC_NO_CHANNEL[CH_W-1:0];
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         fe_reg <= '0;
      end else begin
         fe_reg <= fe_next;
      end
   end
   assign sense_module_enable = fe_reg[0];
   assign reference_mode_sel = fe_reg[1];
   assign current_range_sel = fe_reg[3:2];
   assign charge_source_en = fe_reg[4];
   assign osc_core_en = fe_reg[5];
   assign sense_channel_sel = fe_reg[CH_W+5:6];
   // Channel connect shares the enable flop
   assign channel_connect = fe_reg[0];
   assign reg_rdata = rd_reg;
   assign timer8_overflow = ovf_reg;
endmodule

/* File: verif/csc_checker.sv */
// Port assertions for the sense control block
`timescale 1ns/1ns
module csc_checker #(parameter int CH_W = 4) (
   // Clock, reset and register port
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   // Front end
   input wire logic sense_module_enable,
   input wire logic reference_mode_sel,
   input wire logic [1:0] current_range_sel,
   input wire logic charge_source_en,
   input wire logic osc_core_en,
   input wire logic [CH_W-1:0] sense_channel_sel,
   input wire logic channel_connect,
   input wire logic timer8_overflow
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_enable_write: assert property (
      reg_wr && reg_addr == 4'h0 |-> ##2 sense_module_enable == $past(reg_wdata[7], 2)) else $error("enable bad");
   a_refmode_write: assert property (
      reg_wr && reg_addr == 4'h0 |-> ##2 reference_mode_sel == $past(reg_wdata[6], 2)) else $error("refmode bad");
   a_range_write: assert property (
      reg_wr && reg_addr == 4'h0 |-> ##2 current_range_sel == $past(reg_wdata[3:2], 2)) else $error("range bad");
   a_charge_gate: assert property (
      charge_source_en == (sense_module_enable && current_range_sel != 2'h0)) else $error("charge bad");
   a_core_noise: assert property (
      osc_core_en == (sense_module_enable && (reference_mode_sel || current_range_sel != 2'h0))) else $error("core bad");
   a_connect_enable: assert property (
      channel_connect == sense_module_enable) else $error("connect bad");
   a_channel_idle: assert property (
      !sense_module_enable |-> sense_channel_sel == '0) else $error("channel bad");
   a_overflow_pulse: assert property (
      timer8_overflow |=> !timer8_overflow) else $error("overflow bad");
endmodule
bind csc_top csc_checker #(.CH_W(CH_W)) csc_checker_i (.*);

/* File: verif/csc_pad_model.sv */
// Sensing pad comparator and timer gate source
`timescale 1ns/1ns
module csc_pad_model (
   // Clock and lines
   input wire logic core_clk,
   output logic osc_comp_in,
   output logic timer16_gate_in
);
   initial begin
      osc_comp_in = 1'h0;
      timer16_gate_in = 1'h0;
   end
   task automatic set_lines(input logic osc, input logic gate);
      osc_comp_in <= osc;
      timer16_gate_in <= gate;
   endtask
   // Half period of 3 clocks, slow enough for the sync flops
   task automatic burst(input int n);
      repeat (2 * n) begin
         repeat (3) @(posedge core_clk);
         osc_comp_in <= !osc_comp_in;
      end
   endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the sense control block
`timescale 1ns/1ns
module tb;
   import csc_pkg::*;
   logic core_clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, rd_d = 1'h0, hit;
   logic timer8_ext_clk = 1'h0, timer16_alt_clk = 1'h0, osc_comp_in, timer16_gate_in;
   logic [3:0] reg_addr = 4'h0;
   logic [3:0] sense_channel_sel;
   logic [1:0] current_range_sel;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, ch;
   logic sense_module_enable, reference_mode_sel, charge_source_en, osc_core_en, channel_connect, timer8_overflow;
   logic [15:0] exp_q[$];
   logic [7:0] t16_ctl[5] = '{8'hC1, 8'hC3, 8'hC3, 8'hC0, 8'h41};
   logic [4:0] t16_gate = 5'h1C, t16_cnt = 5'h05;
   int failures = 0, samples_checked = 0, cyc = 0, seed = 65438, n;
   always #10 core_clk = !core_clk;
   csc_top csc_top_i (.*);
   csc_pad_model csc_pad_model_i (.*);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Extra edge at the end keeps back-to-back calls from touching a strobe twice
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      reg_rd <= 1'h1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'h0;
      @(posedge core_clk);
   endtask
   // ********
   // Read monitor and timeout
   // ********
   always @(posedge core_clk) begin
      rd_d <= reg_rd;
      cyc <= cyc + 1;
      if (rd_d) chk(reg_rdata, exp_q.pop_front());
      if (cyc == 5000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      for (int a = 0; a < 16; a += 3) rd(a[3:0], 16'h0000);
      wr(4'hF, 16'hFFFF);
      rd(4'hF, 16'h0000);
      for (int m = 0; m < 8; m++) begin
         wr(4'h0, {9'h001, m[2], 2'h0, m[1:0], 2'h0});
         @(posedge core_clk);
         chk(16'({reference_mode_sel, current_range_sel}), 16'(m[2:0]));
         chk(16'({charge_source_en, osc_core_en}), 16'({m[1:0] != 0, m[1:0] != 0 || m[2]}));
      end
      ch = 16'($random(seed)) & 16'h000F;
      wr(4'h1, ch);
      wr(4'h0, 16'h0000);
      @(posedge core_clk);
      chk(16'({channel_connect, sense_channel_sel}), 16'h0000);
      rd(4'h1, ch);
      wr(4'h0, 16'h0086);
      @(posedge core_clk);
      chk(16'({channel_connect, sense_channel_sel}), ch | 16'h0010);
      csc_pad_model_i.set_lines(1'h1, 1'h0);
      repeat (4) @(posedge core_clk);
      rd(4'h0, 16'h0086);
      csc_pad_model_i.set_lines(1'h0, 1'h0);
      repeat (4) @(posedge core_clk);
      rd(4'h0, 16'h0084);
      n = 3 + ($random(seed) & 7);
      wr(4'h0, 16'h0085);
      wr(4'h4, 16'h0000);
      csc_pad_model_i.burst(n);
      repeat (8) @(posedge core_clk);
      rd(4'h4, n[15:0]);
      // Sense select clear: only the external clock may count, the oscillator not
      wr(4'h0, 16'h0084);
      wr(4'h4, 16'h0000);
      repeat (n) begin
         timer8_ext_clk <= 1'h1;
         repeat (3) @(posedge core_clk);
         timer8_ext_clk <= 1'h0;
         repeat (3) @(posedge core_clk);
      end
      csc_pad_model_i.burst(2);
      repeat (8) @(posedge core_clk);
      rd(4'h4, n[15:0]);
      for (int k = 0; k < 5; k++) begin
         csc_pad_model_i.set_lines(1'h0, t16_gate[k]);
         wr(4'h3, {8'h00, t16_ctl[k]});
         wr(4'h5, 16'h0000);
         csc_pad_model_i.burst(n);
         repeat (8) @(posedge core_clk);
         rd(4'h5, t16_cnt[k] ? n[15:0] : 16'h0000);
      end
      wr(4'h2, 16'h0020);
      wr(4'h4, 16'h00F0);
      hit = 1'h0;
      repeat (40) begin
         @(posedge core_clk);
         hit = hit | (timer8_overflow === 1'h1);
      end
      chk(16'(hit), 16'h0001);
      repeat (3) @(posedge core_clk);
      end_of_test();
   end
endmodule
